// ==== pkg/pplc_regs.vh ====
// register offsets, field positions, reset values and timing counts for the phy port control block
`ifndef PPLC_REGS_VH
`define PPLC_REGS_VH

// register offsets
`define PPLC_P1_FIRST_OFF 8'h1C
`define PPLC_P1_SECOND_OFF 8'h1D
`define PPLC_P2_FIRST_OFF 8'h2C
`define PPLC_P2_SECOND_OFF 8'h2D
`define PPLC_P3_FIRST_OFF 8'h3C
`define PPLC_P3_SECOND_OFF 8'h3D

// first control register fields
`define PPLC_F_ANEG_EN 7
`define PPLC_F_SPEED100 6
`define PPLC_F_DUPLEX 5
`define PPLC_F_ADV_PAUSE 4
`define PPLC_F_ADV_100FD 3
`define PPLC_F_ADV_100HD 2
`define PPLC_F_ADV_10FD 1
`define PPLC_F_ADV_10HD 0
`define PPLC_F_STRAP_HI 7
`define PPLC_F_STRAP_LO 5
`define PPLC_F_ADV_HI 4
`define PPLC_F_ADV_LO 0

// second control register fields
`define PPLC_S_LED_OFF 7
`define PPLC_S_TX_DIS 6
`define PPLC_S_RESTART 5
`define PPLC_S_FEF_DIS 4
`define PPLC_S_POWER_DOWN 3
`define PPLC_S_MDIX_DIS 2
`define PPLC_S_FORCE_MDI 1

// reset values and writable masks
`define PPLC_FIRST_RST 8'hFF
`define PPLC_SECOND_RST 8'h00
`define PPLC_SECOND_MASK 8'hFE
`define PPLC_ADV_RST 5'h1F

// strap capture timing: counter value that raises the load strobe, and the value at which the count stops
`define PPLC_STRAP_LOAD_CNT 2'h2
`define PPLC_STRAP_DONE_CNT 2'h3

`endif

// ==== logic/pplc_strap_sync.v ====
// strap pin synchroniser with a single load pulse after reset release
`timescale 1ns/10ps
`default_nettype none
`include "pplc_regs.vh"

module pplc_strap_sync #(
  parameter W = 6
) (
  // clock and reset
  input wire sys_clk_in,
  input wire nrst_in,
  // strap pins
  input wire [W-1:0] strap_in,
  // synchronised straps and load strobe
  output reg [W-1:0] strap_out,
  output reg load_out
);

  reg [W-1:0] meta;
  reg [1:0] cnt;

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= {W{1'b0}};
      strap_out <= {W{1'b0}};
      cnt <= 2'h0;
      load_out <= 1'b0;
    end else begin
      meta <= strap_in;
      strap_out <= meta;
      load_out <= (cnt == `PPLC_STRAP_LOAD_CNT);
      if (cnt != `PPLC_STRAP_DONE_CNT) begin
        cnt <= cnt + 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/pplc_port_ctl.v ====
// per-port drive of phy controls from the two control registers
`timescale 1ns/10ps
`default_nettype none
`include "pplc_regs.vh"

module pplc_port_ctl (
  // clock and reset
  input wire sys_clk_in,
  input wire nrst_in,
  // register contents
  input wire [7:0] first_in,
  input wire [7:0] second_in,
  input wire restart_req_in,
  // phy core status
  input wire link_up_in,
  input wire aneg_fail_in,
  input wire aneg_full_in,
  input wire led_one_in,
  input wire led_zero_in,
  // phy controls
  output reg aneg_en_out,
  output reg speed100_out,
  output reg duplex_full_out,
  output reg [4:0] adv_ability_out,
  output reg aneg_restart_out,
  output reg tx_enable_out,
  output reg fef_enable_out,
  output reg auto_mdix_en_out,
  output reg force_mdi_out,
  output reg port_led_one_out,
  output reg port_led_zero_out
);

  wire led_off = second_in[`PPLC_S_LED_OFF];
  wire forced = ~first_in[`PPLC_F_ANEG_EN] | aneg_fail_in;

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aneg_en_out <= 1'b1;
      speed100_out <= 1'b1;
      duplex_full_out <= 1'b1;
      adv_ability_out <= `PPLC_ADV_RST;
      aneg_restart_out <= 1'b0;
      tx_enable_out <= 1'b1;
      fef_enable_out <= 1'b1;
      auto_mdix_en_out <= 1'b1;
      force_mdi_out <= 1'b0;
      port_led_one_out <= 1'b1;
      port_led_zero_out <= 1'b1;
    end else begin
      aneg_en_out <= first_in[`PPLC_F_ANEG_EN];
      speed100_out <= first_in[`PPLC_F_SPEED100];
      duplex_full_out <= forced ? first_in[`PPLC_F_DUPLEX] : aneg_full_in;
      // advertised abilities only change on a restart request or while the link is down
      if (restart_req_in || !link_up_in) begin
        adv_ability_out <= first_in[`PPLC_F_ADV_HI:`PPLC_F_ADV_LO];
      end
      aneg_restart_out <= restart_req_in;
      tx_enable_out <= ~second_in[`PPLC_S_TX_DIS];
      fef_enable_out <= ~second_in[`PPLC_S_FEF_DIS];
      auto_mdix_en_out <= ~second_in[`PPLC_S_MDIX_DIS];
      force_mdi_out <= second_in[`PPLC_S_FORCE_MDI];
      port_led_one_out <= led_off | led_one_in;
      port_led_zero_out <= led_off | led_zero_in;
    end
  end

endmodule
`default_nettype wire

// ==== logic/pplc_top.v ====
// phy port link control register bank for the two copper ports
`timescale 1ns/10ps
`default_nettype none
`include "pplc_regs.vh"

module pplc_top #(
  parameter NPORT = 2
) (
  // clock and reset
  input wire sys_clk_in,
  input wire nrst_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // strap pins
  input wire port1_duplex_strap_in,
  input wire port2_duplex_strap_in,
  input wire [NPORT-1:0] aneg_strap_in,
  input wire [NPORT-1:0] speed_strap_in,
  // phy core status, index 0 is port 1
  input wire [NPORT-1:0] link_up_in,
  input wire [NPORT-1:0] aneg_fail_in,
  input wire [NPORT-1:0] aneg_full_in,
  input wire [NPORT-1:0] led_one_in,
  input wire [NPORT-1:0] led_zero_in,
  // phy controls
  output wire [NPORT-1:0] aneg_en_out,
  output wire [NPORT-1:0] speed100_out,
  output wire [NPORT-1:0] duplex_full_out,
  output wire [NPORT*5-1:0] adv_ability_out,
  output wire [NPORT-1:0] aneg_restart_out,
  output wire [NPORT-1:0] tx_enable_out,
  output wire [NPORT-1:0] fef_enable_out,
  output wire [NPORT-1:0] auto_mdix_en_out,
  output wire [NPORT-1:0] force_mdi_out,
  // port leds
  output wire [NPORT-1:0] port_led_one_out,
  output wire [NPORT-1:0] port_led_zero_out
);

  wire [NPORT*8-1:0] first_all;
  wire [NPORT*8-1:0] second_all;
  wire [NPORT-1:0] duplex_strap;
  wire [NPORT*3-1:0] strap_sync;
  wire strap_load;
  reg [7:0] next_rdata;

  assign duplex_strap = {port2_duplex_strap_in, port1_duplex_strap_in};

  // straps pass two flops, then load once just after reset release
  pplc_strap_sync #(
    .W(NPORT * 3)
  ) u_strap (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .strap_in({aneg_strap_in, speed_strap_in, duplex_strap}),
    .strap_out(strap_sync),
    .load_out(strap_load)
  );

  genvar i;
  generate
    for (i = 0; i < NPORT; i = i + 1) begin : g_port
      localparam [7:0] FIRST_OFF = (i == 0) ? `PPLC_P1_FIRST_OFF : `PPLC_P2_FIRST_OFF;
      localparam [7:0] SECOND_OFF = (i == 0) ? `PPLC_P1_SECOND_OFF : `PPLC_P2_SECOND_OFF;
      reg [7:0] first_q;
      reg [7:0] second_q;
      reg restart_req;
      wire hit_first = (reg_addr_in == FIRST_OFF);
      wire hit_second = (reg_addr_in == SECOND_OFF);
      wire [2:0] strap_bits = {strap_sync[2*NPORT+i], strap_sync[NPORT+i], strap_sync[i]};

      always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          first_q <= `PPLC_FIRST_RST;
          second_q <= `PPLC_SECOND_RST;
          restart_req <= 1'b0;
        end else begin
          if (strap_load) begin
            first_q[`PPLC_F_STRAP_HI:`PPLC_F_STRAP_LO] <= strap_bits;
          end else if (reg_wr_in && hit_first) begin
            first_q <= reg_wdata_in;
          end
          if (reg_wr_in && hit_second) begin
            second_q <= reg_wdata_in & `PPLC_SECOND_MASK;
          end
          restart_req <= reg_wr_in && hit_second && reg_wdata_in[`PPLC_S_RESTART];
        end
      end

      assign first_all[i*8 +: 8] = first_q;
      assign second_all[i*8 +: 8] = second_q;

      pplc_port_ctl u_ctl (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .first_in(first_q),
        .second_in(second_q),
        .restart_req_in(restart_req),
        .link_up_in(link_up_in[i]),
        .aneg_fail_in(aneg_fail_in[i]),
        .aneg_full_in(aneg_full_in[i]),
        .led_one_in(led_one_in[i]),
        .led_zero_in(led_zero_in[i]),
        .aneg_en_out(aneg_en_out[i]),
        .speed100_out(speed100_out[i]),
        .duplex_full_out(duplex_full_out[i]),
        .adv_ability_out(adv_ability_out[i*5 +: 5]),
        .aneg_restart_out(aneg_restart_out[i]),
        .tx_enable_out(tx_enable_out[i]),
        .fef_enable_out(fef_enable_out[i]),
        .auto_mdix_en_out(auto_mdix_en_out[i]),
        .force_mdi_out(force_mdi_out[i]),
        .port_led_one_out(port_led_one_out[i]),
        .port_led_zero_out(port_led_zero_out[i])
      );
    end
  endgenerate

  // read decode; port 3 slots and unmapped offsets read zero
  always @* begin
    if (reg_addr_in == `PPLC_P1_FIRST_OFF) begin
      next_rdata = first_all[7:0];
    end else if (reg_addr_in == `PPLC_P1_SECOND_OFF) begin
      next_rdata = second_all[7:0];
    end else if (reg_addr_in == `PPLC_P2_FIRST_OFF) begin
      next_rdata = first_all[15:8];
    end else if (reg_addr_in == `PPLC_P2_SECOND_OFF) begin
      next_rdata = second_all[15:8];
    end else begin
      next_rdata = 8'h00;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ==== logic/pplc_dummy_unused.v ====
// spare design unit: holds no logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== tb/pplc_top_properties.sv ====
// port assertions for the phy port control register bank
`timescale 1ns/10ps
`default_nettype none
module pplc_chk #(
  parameter NPORT = 2
) (
  // clock, reset and register port
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // phy controls and leds
  input wire logic [NPORT-1:0] aneg_restart_out,
  input wire logic [NPORT-1:0] tx_enable_out,
  input wire logic [NPORT-1:0] fef_enable_out,
  input wire logic [NPORT-1:0] auto_mdix_en_out,
  input wire logic [NPORT-1:0] force_mdi_out,
  input wire logic [NPORT-1:0] port_led_one_out,
  input wire logic [NPORT-1:0] port_led_zero_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  a_tx_dis_p1: assert property (reg_wr_in && reg_addr_in == 8'h1D
    |-> ##2 tx_enable_out[0] == !$past(reg_wdata_in[6], 2)) else $error("tx enable wrong");
  a_tx_dis_p2: assert property (reg_wr_in && reg_addr_in == 8'h2D
    |-> ##2 tx_enable_out[1] == !$past(reg_wdata_in[6], 2)) else $error("tx enable wrong");
  a_led_off: assert property (reg_wr_in && reg_addr_in == 8'h2D && reg_wdata_in[7]
    |-> ##2 port_led_one_out[1] && port_led_zero_out[1]) else $error("leds not off");
  a_restart_cause: assert property ($rose(aneg_restart_out[0])
    |-> $past(reg_wr_in, 2) && $past(reg_addr_in, 2) == 8'h1D && $past(reg_wdata_in[5], 2))
    else $error("restart without write");
  a_restart_pulse: assert property (reg_wr_in && reg_addr_in == 8'h2D && reg_wdata_in[5]
    |-> ##2 aneg_restart_out[1]) else $error("restart missing");
  a_fef_dis: assert property (reg_wr_in && reg_addr_in == 8'h2D
    |-> ##2 fef_enable_out[1] == !$past(reg_wdata_in[4], 2)) else $error("far-end fault enable wrong");
  a_mdix_mode: assert property (reg_wr_in && reg_addr_in == 8'h1D
    |-> ##2 auto_mdix_en_out[0] == !$past(reg_wdata_in[2], 2) && force_mdi_out[0] == $past(reg_wdata_in[1], 2))
    else $error("crossover control wrong");
  a_rsvd_read: assert property (reg_rd_in && reg_addr_in[7:4] == 4'h3
    |=> reg_rdata_out == 8'h00) else $error("reserved read not zero");
endmodule
`default_nettype wire

// ==== tb/pplc_link_partner.sv ====
// cable link partner: renegotiates after each restart pulse
`timescale 1ns/10ps
`default_nettype none
module pplc_link_partner #(
  parameter DLY = 6,
  parameter [4:0] ABIL = 5'h1F
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // from the port
  input wire logic aneg_restart_in,
  input wire logic [4:0] adv_in,
  // phy core status
  output logic link_up_out,
  output logic aneg_fail_out,
  output logic aneg_full_out,
  output logic led_one_out,
  output logic led_zero_out
);
  logic [7:0] cnt;
  logic [3:0] c;
  assign c = adv_in[3:0] & ABIL[3:0];
  // leds are active low
  assign led_one_out = ~link_up_out;
  assign led_zero_out = ~aneg_full_out;
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link_up_out <= 1'b0;
      aneg_fail_out <= 1'b0;
      aneg_full_out <= 1'b0;
      cnt <= 8'h00;
    end else if (aneg_restart_in) begin
      link_up_out <= 1'b0;
      cnt <= 8'(DLY);
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) begin
        // best common ability wins
        link_up_out <= 1'b1;
        aneg_fail_out <= ~|c;
        aneg_full_out <= c[3] | (~c[2] & c[1]);
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/pplc_top_tb_top.sv ====
// self-checking bench for the phy port control register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; $display("Error %s exp %h got %h", n, e, a); end end
module pplc_top_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] cfg [3] = '{8'h8A, 8'hB5, 8'hA0};
  logic [2:0] ex = 3'b101;
  logic [4:0] last = 5'h1F;
  wire [7:0] rdata;
  wire [1:0] aen, spd, dup, rstp, txe, fef, mdx, fmdi, lone, lzero, lup, afail, afull, l1, l0;
  wire [9:0] adv;
  int mismatches = 0, compares = 0, npulse = 0, i, p;
  always #50 clk = ~clk;
  always @(posedge clk) if (rstp[0] === 1'b1) npulse++;
  pplc_top pplc_top_i (.sys_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .port1_duplex_strap_in(1'b0), .port2_duplex_strap_in(1'b1),
    .aneg_strap_in(2'b01), .speed_strap_in(2'b10), .link_up_in(lup), .aneg_fail_in(afail), .aneg_full_in(afull),
    .led_one_in(l1), .led_zero_in(l0), .aneg_en_out(aen), .speed100_out(spd), .duplex_full_out(dup),
    .adv_ability_out(adv), .aneg_restart_out(rstp), .tx_enable_out(txe), .fef_enable_out(fef),
    .auto_mdix_en_out(mdx), .force_mdi_out(fmdi), .port_led_one_out(lone), .port_led_zero_out(lzero));
  for (genvar g = 0; g < 2; g++) begin : lp
    pplc_link_partner pplc_link_partner_i (.sys_clk_in(clk), .nrst_in(nrst), .aneg_restart_in(rstp[g]),
      .adv_in(adv[g*5+:5]), .link_up_out(lup[g]), .aneg_fail_out(afail[g]), .aneg_full_out(afull[g]),
      .led_one_out(l1[g]), .led_zero_out(l0[g]));
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] got;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // read data stands only until this edge; take it here
    @(posedge clk);
    got = rdata;
    #1;
    `CHK("read data", e, got)
  endtask
  task automatic link_wait(input int q);
    for (i = 0; i < 40 && lup[q] !== 1'b1; i++) @(posedge clk);
    if (i == 40) begin
      mismatches++;
      end_sim;
    end else begin
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    rd8(8'h1C, 8'h9F);
    rd8(8'h2C, 8'h7F);
    rd8(8'h3C, 8'h00);
    rd8(8'h3D, 8'h00);
    rd8(8'h50, 8'h00);
    `CHK("forced mode p2", 3'b011, {aen[1], spd[1], dup[1]})
    wr8(8'h2C, 8'h5F);
    `CHK("duplex p2", 1'b0, dup[1])
    for (p = 0; p < 2; p++) begin
      wr8(8'h1D + 8'(p * 16), 8'h20);
      link_wait(p);
      `CHK("leds on", 2'b00, {lone[p], lzero[p]})
      wr8(8'h1D + 8'(p * 16), 8'hD7);
      `CHK("controls set", 6'b000111, {txe[p], fef[p], mdx[p], fmdi[p], lone[p], lzero[p]})
      rd8(8'h1D + 8'(p * 16), 8'hD6);
      wr8(8'h1D + 8'(p * 16), 8'h04);
      `CHK("controls clear", 6'b110000, {txe[p], fef[p], mdx[p], fmdi[p], lone[p], lzero[p]})
      `CHK("other port", 1'b1, txe[1-p])
    end
    for (p = 0; p < 3; p++) begin
      wr8(8'h1C, cfg[p]);
      `CHK("adv held", last, adv[4:0])
      wr8(8'h1D, 8'h20);
      `CHK("adv", cfg[p][4:0], adv[4:0])
      link_wait(0);
      `CHK("duplex", ex[p], dup[0])
      last = cfg[p][4:0];
    end
    `CHK("restarts", 4, npulse)
    end_sim;
  end
endmodule
bind pplc_top pplc_chk #(.NPORT(NPORT)) pplc_chk_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .aneg_restart_out(aneg_restart_out), .tx_enable_out(tx_enable_out),
  .fef_enable_out(fef_enable_out), .auto_mdix_en_out(auto_mdix_en_out), .force_mdi_out(force_mdi_out),
  .port_led_one_out(port_led_one_out), .port_led_zero_out(port_led_zero_out));
`default_nettype wire
